/* File: common/wprs_defines.svh */
// Constants of the power and reset sequencer
`ifndef WPRS_DEFINES_SVH
`define WPRS_DEFINES_SVH

// ----------------------------------------
// Pads and timing
// ----------------------------------------
`define WPRS_PAD_COUNT 9
`define WPRS_XO_SETTLE_MS 5
`define WPRS_CLK_SYS_KHZ 125000
`define WPRS_SETTLE_CNT_W 20

// ----------------------------------------
// Reset values
// ----------------------------------------
`define WPRS_SYNC_RST_VAL 1'h0

`endif

/* File: common/wprs_pkg.sv */
// Types of the power and reset sequencer
package wprs_pkg;

  // ----------------------------------------
  // Pad phases and device states
  // ----------------------------------------
  typedef enum logic [1:0] {
    PH_DOWN    = 2'b00,
    PH_POR     = 2'b01,
    PH_DEFAULT = 2'b10,
    PH_PROG    = 2'b11
  } wprs_phase_t;

  typedef enum logic [1:0] {
    ST_DOWN = 2'b00,
    ST_DOZE = 2'b01,
    ST_RX   = 2'b10,
    ST_TX   = 2'b11
  } wprs_dev_state_t;

endpackage

/* File: core/wprs_sync.sv */
// Two flip-flop synchroniser for one pin
module wprs_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic d,
  output logic q
);

  logic meta_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= 1'h0;
      q <= 1'h0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule

/* File: core/wprs_top.sv */
// Power state and digital pad control of the wireless link controller
// Summary of operation
// - The device reports transmitting, receiving, idle on, or powered down.
// - With supply-enable and reset low, pads have output, input and pull all disabled.
// - With supply-enable high and reset low, outputs and inputs are off and pulls are on.
// - Out of reset but unprogrammed, outputs are off while inputs and pulls are on.
// - Once programmed, output and pull follow firmware and input is on exactly when output is off.
`include "wprs_defines.svh"

module wprs_top
  import wprs_pkg::*;
#(
  parameter int XO_SETTLE_CYCLES = `WPRS_XO_SETTLE_MS * `WPRS_CLK_SYS_KHZ
) (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic SUPPLY_EN,
  input wire logic HARD_RESET_N,
  input wire logic CFG_LOAD,
  input wire logic [`WPRS_PAD_COUNT-1:0] CFG_OUT_EN,
  input wire logic [`WPRS_PAD_COUNT-1:0] CFG_PULL_EN,
  input wire logic TX_ACTIVE,
  input wire logic RX_ACTIVE,
  output logic [`WPRS_PAD_COUNT-1:0] PAD_OUT_EN,
  output logic [`WPRS_PAD_COUNT-1:0] PAD_IN_EN,
  output logic [`WPRS_PAD_COUNT-1:0] PAD_PULL_EN,
  output wprs_dev_state_t DEV_STATE,
  output logic [1:0] PAD_PHASE,
  output logic XO_EARLY
);

  localparam int PW = `WPRS_PAD_COUNT;
  localparam logic [`WPRS_SETTLE_CNT_W-1:0] SETTLE_LIM = `WPRS_SETTLE_CNT_W'(XO_SETTLE_CYCLES);

  logic en_s;
  logic rst_n_s;
  wprs_phase_t phase_q;
  wprs_phase_t phase_d;
  logic [PW-1:0] cfg_oe_q;
  logic [PW-1:0] cfg_pull_q;
  logic [`WPRS_SETTLE_CNT_W-1:0] settle_q;
  logic [PW-1:0] oe_q;
  logic [PW-1:0] ie_q;
  logic [PW-1:0] pull_q;
  wprs_dev_state_t dev_q;
  logic early_q;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  wprs_sync u_sync_en (
    .clk(CLK_SYS),
    .rst(RESET),
    .d(SUPPLY_EN),
    .q(en_s)
  );

  wprs_sync u_sync_rst (
    .clk(CLK_SYS),
    .rst(RESET),
    .d(HARD_RESET_N),
    .q(rst_n_s)
  );

  // ----------------------------------------
  // Pad phase
  // ----------------------------------------
  always_comb begin
    phase_d = phase_q;
    if (!en_s) begin
      phase_d = PH_DOWN;
    end else if (!rst_n_s) begin
      phase_d = PH_POR;
    end else begin
      unique case (phase_q)
        PH_DOWN: phase_d = PH_POR;
        PH_POR: phase_d = PH_DEFAULT;
        PH_DEFAULT: phase_d = CFG_LOAD ? PH_PROG : PH_DEFAULT;
        PH_PROG: phase_d = PH_PROG;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      phase_q <= PH_DOWN;
    end else begin
      phase_q <= phase_d;
    end
  end

  // ----------------------------------------
  // Firmware pad configuration
  // ----------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      cfg_oe_q <= '0;
      cfg_pull_q <= '0;
    end else if (phase_q == PH_DOWN || phase_q == PH_POR) begin
      cfg_oe_q <= '0;
      cfg_pull_q <= '0;
    end else if (CFG_LOAD) begin
      cfg_oe_q <= CFG_OUT_EN;
      cfg_pull_q <= CFG_PULL_EN;
    end
  end

  // ----------------------------------------
  // Pad drivers
  // ----------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      oe_q <= '0;
      ie_q <= '0;
      pull_q <= '0;
    end else begin
      unique case (phase_q)
        PH_DOWN: begin
          oe_q <= '0;
          ie_q <= '0;
          pull_q <= '0;
        end
        PH_POR: begin
          oe_q <= '0;
          ie_q <= '0;
          pull_q <= '1;
        end
        PH_DEFAULT: begin
          oe_q <= '0;
          ie_q <= '1;
          pull_q <= '1;
        end
        PH_PROG: begin
          oe_q <= cfg_oe_q;
          ie_q <= ~cfg_oe_q;
          pull_q <= cfg_pull_q;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Device state
  // ----------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      dev_q <= ST_DOWN;
    end else if (phase_q == PH_DOWN) begin
      dev_q <= ST_DOWN;
    end else if (TX_ACTIVE) begin
      dev_q <= ST_TX;
    end else if (RX_ACTIVE) begin
      dev_q <= ST_RX;
    end else begin
      dev_q <= ST_DOZE;
    end
  end

  // ----------------------------------------
  // Oscillator settle check
  // ----------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (RESET || !en_s) begin
      settle_q <= '0;
    end else if (settle_q != SETTLE_LIM) begin
      settle_q <= settle_q + `WPRS_SETTLE_CNT_W'(1);
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET || !en_s) begin
      early_q <= 1'h0;
    end else if (phase_q == PH_POR && rst_n_s && settle_q != SETTLE_LIM) begin
      early_q <= 1'h1;
    end
  end

  assign PAD_OUT_EN = oe_q;
  assign PAD_IN_EN = ie_q;
  assign PAD_PULL_EN = pull_q;
  assign DEV_STATE = dev_q;
  assign PAD_PHASE = phase_q;
  assign XO_EARLY = early_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  down_pads_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    phase_q == PH_DOWN |=> oe_q == '0 && ie_q == '0 && pull_q == '0)
    else $error("pads not fully off in power-down");

  en_low_down_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    !en_s |=> phase_q == PH_DOWN ##1 (pull_q == '0))
    else $error("enable low did not reach power-down");

  por_pads_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    en_s && !rst_n_s |=> phase_q == PH_POR ##1 (oe_q == '0 && ie_q == '0 && pull_q == '1))
    else $error("pads wrong while held in reset");

  default_pads_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    phase_q == PH_DEFAULT |=> oe_q == '0 && ie_q == '1 && pull_q == '1)
    else $error("pads wrong before programming");

  prog_follow_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    phase_q == PH_PROG |=> oe_q == $past(cfg_oe_q) && pull_q == $past(cfg_pull_q))
    else $error("pads do not follow firmware setting");

  input_opposite_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    phase_q == PH_PROG |=> ie_q == ~oe_q)
    else $error("input buffer not opposite of driver");

  load_prog_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    phase_q == PH_DEFAULT && en_s && rst_n_s && CFG_LOAD |=> phase_q == PH_PROG && cfg_oe_q == $past(CFG_OUT_EN))
    else $error("load did not program pads");

  state_down_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    phase_q == PH_DOWN |=> dev_q == ST_DOWN)
    else $error("state not down while powered down");

  state_tx_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    phase_q != PH_DOWN && TX_ACTIVE |=> dev_q == ST_TX)
    else $error("state not transmit");

  state_rx_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    phase_q != PH_DOWN && !TX_ACTIVE && RX_ACTIVE |=> dev_q == ST_RX)
    else $error("state not receive");

  state_doze_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    phase_q != PH_DOWN && !TX_ACTIVE && !RX_ACTIVE |=> dev_q == ST_DOZE)
    else $error("state not idle on");

endmodule

/* File: testbench/test_wprs_top.sv */
// Self-checking bench of the power and reset sequencer
module test_wprs_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'h0, reset = 1'h1, pwr_req = 1'h0, early = 1'h0, cfg_load = 1'h0, tx = 1'h0, rx = 1'h0;
  logic supply_en, hard_reset_n, xo_early;
  logic [8:0] cfg_out = 9'h000, cfg_pull = 9'h000, out_en, in_en, pull_en;
  logic [1:0] phase;
  wprs_pkg::wprs_dev_state_t dev_state;
  int n_fail = 0, checks_done = 0, cycles = 0;
  always #4 clk_sys = ~clk_sys;
  wprs_host_model #(.HOLD(60)) host (.clk(clk_sys), .pwr_req(pwr_req), .early(early),
    .supply_en(supply_en), .hard_reset_n(hard_reset_n));
  wprs_top #(.XO_SETTLE_CYCLES(50)) DUT (.CLK_SYS(clk_sys), .RESET(reset), .SUPPLY_EN(supply_en),
    .HARD_RESET_N(hard_reset_n), .CFG_LOAD(cfg_load), .CFG_OUT_EN(cfg_out), .CFG_PULL_EN(cfg_pull),
    .TX_ACTIVE(tx), .RX_ACTIVE(rx), .PAD_OUT_EN(out_en), .PAD_IN_EN(in_en), .PAD_PULL_EN(pull_en),
    .DEV_STATE(dev_state), .PAD_PHASE(phase), .XO_EARLY(xo_early));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      report_and_stop();
    end
  end
  task automatic chk(input string what, input logic [8:0] seen, input logic [8:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wait_phase(input logic [1:0] p);
    for (int i = 0; i < 200 && phase !== p; i++) cyc(1);
    chk("phase", {7'h00, phase}, {7'h00, p});
    cyc(2);
  endtask
  task automatic pads(input logic [8:0] o, input logic [8:0] i, input logic [8:0] p);
    chk("out_en", out_en, o);
    chk("in_en", in_en, i);
    chk("pull_en", pull_en, p);
  endtask
  task automatic load(input logic [8:0] o1, input logic [8:0] p1, input logic [8:0] o2, input logic [8:0] p2);
    @(posedge clk_sys);
    cfg_load <= 1'h1;
    cfg_out <= o1;
    cfg_pull <= p1;
    @(posedge clk_sys);
    cfg_out <= o2;
    cfg_pull <= p2;
    @(posedge clk_sys);
    cfg_load <= 1'h0;
    cyc(3);
  endtask
  task automatic t_up();
    @(posedge clk_sys);
    pwr_req <= 1'h1;
    wait_phase(2'h1);
    pads(9'h000, 9'h000, 9'h1FF);
    load(9'h0FF, 9'h0FF, 9'h0FF, 9'h0FF);
    chk("load in reset", {7'h00, phase}, 9'h001);
    pads(9'h000, 9'h000, 9'h1FF);
    wait_phase(2'h2);
    pads(9'h000, 9'h1FF, 9'h1FF);
    chk("xo_early", {8'h00, xo_early}, 9'h000);
    $display("test power up done");
  endtask
  task automatic t_prog();
    load(9'h0A5, 9'h13C, 9'h0A5, 9'h13C);
    chk("prog phase", {7'h00, phase}, 9'h003);
    pads(9'h0A5, 9'h15A, 9'h13C);
    load(9'h1FF, 9'h000, 9'h003, 9'h1F0);
    pads(9'h003, 9'h1FC, 9'h1F0);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      tx <= i[1];
      rx <= i[0];
      cyc(2);
      chk("dev_state", {7'h00, dev_state}, i[1] ? 9'h003 : (i[0] ? 9'h002 : 9'h001));
    end
    @(posedge clk_sys);
    tx <= 1'h0;
    rx <= 1'h0;
    cyc(2);
    chk("dev_state idle", {7'h00, dev_state}, 9'h001);
    $display("test programming done");
  endtask
  task automatic t_off();
    @(posedge clk_sys);
    pwr_req <= 1'h0;
    wait_phase(2'h0);
    pads(9'h000, 9'h000, 9'h000);
    chk("down state", {7'h00, dev_state}, 9'h000);
    chk("xo cleared", {8'h00, xo_early}, 9'h000);
    $display("test power down done");
  endtask
  task automatic t_early();
    @(posedge clk_sys);
    early <= 1'h1;
    pwr_req <= 1'h1;
    wait_phase(2'h2);
    chk("xo early", {8'h00, xo_early}, 9'h001);
    $display("test early release done");
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    reset <= 1'h0;
    cyc(2);
    pads(9'h000, 9'h000, 9'h000);
    t_up();
    t_prog();
    t_off();
    t_early();
    t_off();
    report_and_stop();
  end
endmodule

/* File: testbench/wprs_host_model.sv */
// Host power sequencer model driving supply-enable and hard reset
module wprs_host_model #(
  parameter int HOLD = 60
) (
  input wire logic clk,
  input wire logic pwr_req,
  input wire logic early,
  output logic supply_en,
  output logic hard_reset_n
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // Pins always at a defined level, never floating
  initial begin
    supply_en = 1'h0;
    hard_reset_n = 1'h0;
    cnt = 0;
  end
  // I/O supply is taken as on for the whole run
  always @(posedge clk) begin
    if (!pwr_req) begin
      supply_en <= 1'h0;
      hard_reset_n <= 1'h0;
      cnt <= 0;
    end else begin
      supply_en <= 1'h1;
      cnt <= cnt + 1;
      if (cnt >= (early ? 10 : HOLD)) hard_reset_n <= 1'h1;
    end
  end
endmodule
